// ==== sag_addr_gen.sv ====
// Purpose: operand address generation: segment choice plus 16-bit offset
// Assumes: decoder presents one request per cycle; general registers come in as a flat word array
// Notes:   answer is registered and appears on the edge after the request
`timescale 1ns/100ps
`default_nettype none
module sag_addr_gen
	import sag_pkg::*;
(
	// clock and reset
	input  wire logic          core_clk,
	input  wire logic          reset_n,
	// decoder request
	input  wire sag_req_t      reqIn,
	// register state
	input  wire sag_gpr_t      gprFile,
	input  wire sag_seg_load_t segLoad,
	// answer to the bus side
	output sag_ans_t           ansOut
);
	import sag_pkg::*;

	sag_ans_t    ans_ff;
	sag_ans_t    nxt_ans;
	sag_seg_t    implicitSeg;
	sag_seg_t    chosenSeg;
	logic [15:0] segValue;
	logic        useDisp;
	logic        useBase;
	logic        useIndex;
	logic        isMemMode;
	logic [15:0] baseValue;
	logic [15:0] indexValue;
	logic [15:0] memOffset;
	logic [15:0] regOperand;

	sag_seg_bank u_seg_bank (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.segLoad   (segLoad),
		.readId    (chosenSeg),
		.readValue (segValue)
	);

	assign isMemMode = (reqIn.mode != MODE_REGISTER) && (reqIn.mode != MODE_IMMEDIATE);

	// term selection per memory mode
	always_comb begin
		useDisp    = 1'b0;
		useBase    = 1'b0;
		useIndex   = 1'b0;
		baseValue  = reqIn.baseIsPointer ? gprFile[GPR_BASE_POINTER] : gprFile[GPR_BASE_GENERAL];
		indexValue = reqIn.indexIsDest ? gprFile[GPR_DEST_INDEX] : gprFile[GPR_SOURCE_INDEX];
		unique case (reqIn.mode)
			MODE_REGISTER, MODE_IMMEDIATE: begin
			end
			MODE_DIRECT: begin
				useDisp = 1'b1;
			end
			MODE_REG_INDIRECT: begin
				useBase = 1'b1;
				unique case (reqIn.indirSel)
					INDIR_SOURCE_INDEX: baseValue = gprFile[GPR_SOURCE_INDEX];
					INDIR_DEST_INDEX:   baseValue = gprFile[GPR_DEST_INDEX];
					INDIR_BASE_GENERAL: baseValue = gprFile[GPR_BASE_GENERAL];
					INDIR_BASE_POINTER: baseValue = gprFile[GPR_BASE_POINTER];
				endcase
			end
			MODE_BASED: begin
				useDisp = 1'b1;
				useBase = 1'b1;
			end
			MODE_INDEXED: begin
				useDisp  = 1'b1;
				useIndex = 1'b1;
			end
			MODE_BASED_INDEXED: begin
				useBase  = 1'b1;
				useIndex = 1'b1;
			end
			MODE_BASED_IDX_DISP: begin
				useDisp  = 1'b1;
				useBase  = 1'b1;
				useIndex = 1'b1;
			end
		endcase
	end

	sag_offset_sum u_offset_sum (
		.useDisp    (useDisp),
		.dispWide   (reqIn.dispWide),
		.disp       (reqIn.disp),
		.useBase    (useBase),
		.baseValue  (baseValue),
		.useIndex   (useIndex),
		.indexValue (indexValue),
		.offset     (memOffset)
	);

	// implicit segment choice, then override for operand references only
	always_comb begin
		implicitSeg = SEG_DATA;
		unique case (reqIn.refKind)
			REF_PREFETCH: implicitSeg = SEG_CODE;
			REF_STACK:    implicitSeg = SEG_STACK;
			REF_STRDST:   implicitSeg = SEG_EXTRA;
			REF_OPERAND: begin
				if ((reqIn.mode == MODE_REG_INDIRECT) && (reqIn.indirSel == INDIR_BASE_POINTER)) begin
					implicitSeg = SEG_STACK;
				end else if (reqIn.baseIsPointer && ((reqIn.mode == MODE_BASED) ||
						(reqIn.mode == MODE_BASED_INDEXED) || (reqIn.mode == MODE_BASED_IDX_DISP))) begin
					implicitSeg = SEG_STACK;
				end
			end
		endcase
		// prefetch, push/pop and string destination keep their fixed segment
		chosenSeg = implicitSeg;
		if ((reqIn.refKind == REF_OPERAND) && reqIn.overrideValid) begin
			chosenSeg = reqIn.overrideSeg;
		end
	end

	// register operand: byte codes 4..7 are the high halves of registers 0..3
	always_comb begin
		if (reqIn.regWide) begin
			regOperand = gprFile[reqIn.regSel];
		end else if (reqIn.regSel[2]) begin
			regOperand = {8'h00, gprFile[{1'b0, reqIn.regSel[1:0]}][15:8]};
		end else begin
			regOperand = {8'h00, gprFile[reqIn.regSel][7:0]};
		end
	end

	always_comb begin
		nxt_ans          = '0;
		nxt_ans.valid    = reqIn.valid;
		nxt_ans.segId    = chosenSeg;
		nxt_ans.segValue = segValue;
		unique case (reqIn.refKind)
			REF_PREFETCH, REF_STACK: begin
				// decoder supplies the instruction or stack pointer in disp
				nxt_ans.memAccess = 1'b1;
				nxt_ans.offset    = reqIn.disp;
			end
			REF_STRDST: begin
				nxt_ans.memAccess = 1'b1;
				nxt_ans.offset    = gprFile[GPR_DEST_INDEX];
			end
			REF_OPERAND: begin
				if (reqIn.mode == MODE_REGISTER) begin
					nxt_ans.operandValid = 1'b1;
					nxt_ans.operand      = regOperand;
				end else if (reqIn.mode == MODE_IMMEDIATE) begin
					nxt_ans.operandValid = 1'b1;
					nxt_ans.operand      = reqIn.regWide ? reqIn.immValue : {8'h00, reqIn.immValue[7:0]};
				end else begin
					nxt_ans.memAccess = isMemMode;
					nxt_ans.offset    = memOffset;
				end
			end
		endcase
		if (!reqIn.valid) begin
			nxt_ans.memAccess    = 1'b0;
			nxt_ans.operandValid = 1'b0;
		end
	end

	// registered answer: adds a cycle but keeps the adder off the bus-side timing path
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ans_ff <= '0;
		end else begin
			ans_ff <= nxt_ans;
		end
	end

	assign ansOut = ans_ff;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	prefetch_code_a: assert property (
		reqIn.valid && reqIn.refKind == REF_PREFETCH |=> ans_ff.memAccess && ans_ff.segId == SEG_CODE
	) else $error("prefetch did not use code segment");

	stack_seg_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && !reqIn.overrideValid
			&& reqIn.mode == MODE_BASED && reqIn.baseIsPointer |=> ans_ff.segId == SEG_STACK
	) else $error("base pointer reference not in stack segment");

	string_dest_a: assert property (
		reqIn.valid && reqIn.refKind == REF_STRDST
			|=> ans_ff.segId == SEG_EXTRA && ans_ff.offset == $past(gprFile[GPR_DEST_INDEX])
	) else $error("string destination address wrong");

	override_seg_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && reqIn.overrideValid && isMemMode
			|=> ans_ff.segId == $past(reqIn.overrideSeg)
	) else $error("override segment not applied");

	data_default_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && !reqIn.overrideValid && reqIn.mode == MODE_DIRECT
			|=> ans_ff.segId == SEG_DATA
	) else $error("direct reference not in data segment");

	register_mode_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && reqIn.mode == MODE_REGISTER && reqIn.regWide
			|=> !ans_ff.memAccess && ans_ff.operandValid && ans_ff.operand == $past(gprFile[reqIn.regSel])
	) else $error("register operand wrong");

	immediate_mode_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && reqIn.mode == MODE_IMMEDIATE && reqIn.regWide
			|=> !ans_ff.memAccess && ans_ff.operand == $past(reqIn.immValue)
	) else $error("immediate operand wrong");

	direct_short_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && reqIn.mode == MODE_DIRECT && !reqIn.dispWide
			|=> ans_ff.offset == {{8{$past(reqIn.disp[7])}}, $past(reqIn.disp[7:0])}
	) else $error("short displacement not sign extended");

	based_indexed_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && reqIn.mode == MODE_BASED_INDEXED
			&& !reqIn.baseIsPointer && !reqIn.indexIsDest
			|=> ans_ff.offset == 16'($past(gprFile[GPR_BASE_GENERAL]) + $past(gprFile[GPR_SOURCE_INDEX]))
	) else $error("based indexed offset wrong");

	idle_quiet_a: assert property (
		!reqIn.valid |=> !ans_ff.valid && !ans_ff.memAccess && !ans_ff.operandValid
	) else $error("answer without request");

	answer_valid_a: assert property (
		reqIn.valid |=> ans_ff.valid
	) else $error("request without answer");

	mem_access_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && isMemMode
			|=> ans_ff.memAccess && !ans_ff.operandValid
	) else $error("memory mode answer wrong");

	stack_push_a: assert property (
		reqIn.valid && reqIn.refKind == REF_STACK
			|=> ans_ff.memAccess && ans_ff.segId == SEG_STACK && ans_ff.offset == $past(reqIn.disp)
	) else $error("stack access not in stack segment");

	indirect_stack_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && !reqIn.overrideValid
			&& reqIn.mode == MODE_REG_INDIRECT && reqIn.indirSel == INDIR_BASE_POINTER
			|=> ans_ff.segId == SEG_STACK
	) else $error("base pointer indirect not in stack segment");

	direct_wide_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && reqIn.mode == MODE_DIRECT && reqIn.dispWide
			|=> ans_ff.memAccess && ans_ff.offset == $past(reqIn.disp)
	) else $error("direct offset wrong");

	indirect_dest_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && reqIn.mode == MODE_REG_INDIRECT
			&& reqIn.indirSel == INDIR_DEST_INDEX
			|=> ans_ff.offset == $past(gprFile[GPR_DEST_INDEX])
	) else $error("register indirect offset wrong");

	based_wide_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && reqIn.mode == MODE_BASED
			&& !reqIn.baseIsPointer && reqIn.dispWide
			|=> ans_ff.offset == 16'($past(gprFile[GPR_BASE_GENERAL]) + $past(reqIn.disp))
	) else $error("based offset wrong");

	based_short_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && reqIn.mode == MODE_BASED
			&& reqIn.baseIsPointer && !reqIn.dispWide
			|=> ans_ff.offset == 16'($past(gprFile[GPR_BASE_POINTER])
				+ {{8{$past(reqIn.disp[7])}}, $past(reqIn.disp[7:0])})
	) else $error("based short displacement wrong");

	indexed_wide_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && reqIn.mode == MODE_INDEXED
			&& reqIn.indexIsDest && reqIn.dispWide
			|=> ans_ff.offset == 16'($past(gprFile[GPR_DEST_INDEX]) + $past(reqIn.disp))
	) else $error("indexed offset wrong");

	three_term_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && reqIn.mode == MODE_BASED_IDX_DISP
			&& !reqIn.baseIsPointer && reqIn.indexIsDest && reqIn.dispWide
			|=> ans_ff.offset == 16'($past(gprFile[GPR_BASE_GENERAL])
				+ $past(gprFile[GPR_DEST_INDEX]) + $past(reqIn.disp))
	) else $error("three term offset wrong");

	byte_reg_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && reqIn.mode == MODE_REGISTER
			&& !reqIn.regWide && reqIn.regSel[2]
			|=> ans_ff.operandValid && ans_ff.operand == {8'h00, $past(gprFile[{1'b0, reqIn.regSel[1:0]}][15:8])}
	) else $error("high byte register operand wrong");

	imm_byte_a: assert property (
		reqIn.valid && reqIn.refKind == REF_OPERAND && reqIn.mode == MODE_IMMEDIATE && !reqIn.regWide
			|=> !ans_ff.memAccess && ans_ff.operandValid
			&& ans_ff.operand == {8'h00, $past(reqIn.immValue[7:0])}
	) else $error("byte immediate operand wrong");
endmodule
`default_nettype wire

// ==== sag_pkg.sv ====
// Purpose: shared types and constants for the segmented address generator
// Assumes: 16-bit offsets and selectors; eight general registers indexed 0..7
// Notes:   segment ids and register indices are shared by the decoder and the bus side
package sag_pkg;

	localparam int SAG_WORD_W = 16;

	// general register indices; byte registers 0..3 are low halves, 4..7 high halves of 0..3
	localparam logic [2:0] GPR_STACK_POINTER   = 3'h4;
	localparam logic [2:0] GPR_BASE_GENERAL    = 3'h3;
	localparam logic [2:0] GPR_BASE_POINTER    = 3'h5;
	localparam logic [2:0] GPR_SOURCE_INDEX    = 3'h6;
	localparam logic [2:0] GPR_DEST_INDEX      = 3'h7;

	// register indirect choice
	localparam logic [1:0] INDIR_SOURCE_INDEX  = 2'h0;
	localparam logic [1:0] INDIR_DEST_INDEX    = 2'h1;
	localparam logic [1:0] INDIR_BASE_GENERAL  = 2'h2;
	localparam logic [1:0] INDIR_BASE_POINTER  = 2'h3;

	localparam logic [15:0] SEG_RESET_VALUE    = 16'h0000;
	localparam logic [15:0] WORD_ZERO          = 16'h0000;
	localparam int          BYTE_SIGN_BIT      = 7;
	localparam int          BYTE_W             = 8;

	typedef enum logic [1:0] {
		SEG_EXTRA = 2'b00,
		SEG_CODE  = 2'b01,
		SEG_STACK = 2'b10,
		SEG_DATA  = 2'b11
	} sag_seg_t;

	typedef enum logic [2:0] {
		MODE_REGISTER        = 3'b000,
		MODE_IMMEDIATE       = 3'b001,
		MODE_DIRECT          = 3'b010,
		MODE_REG_INDIRECT    = 3'b011,
		MODE_BASED           = 3'b100,
		MODE_INDEXED         = 3'b101,
		MODE_BASED_INDEXED   = 3'b110,
		MODE_BASED_IDX_DISP  = 3'b111
	} sag_mode_t;

	typedef enum logic [1:0] {
		REF_OPERAND  = 2'b00,
		REF_PREFETCH = 2'b01,
		REF_STACK    = 2'b10,
		REF_STRDST   = 2'b11
	} sag_ref_t;

	typedef logic [7:0][15:0] sag_gpr_t;

	typedef struct packed {
		logic        valid;
		sag_ref_t    refKind;
		sag_mode_t   mode;
		logic        overrideValid;
		sag_seg_t    overrideSeg;
		logic        baseIsPointer;
		logic        indexIsDest;
		logic [1:0]  indirSel;
		logic        dispWide;
		logic [15:0] disp;
		logic        regWide;
		logic [2:0]  regSel;
		logic [15:0] immValue;
	} sag_req_t;

	typedef struct packed {
		logic        valid;
		logic        memAccess;
		sag_seg_t    segId;
		logic [15:0] segValue;
		logic [15:0] offset;
		logic        operandValid;
		logic [15:0] operand;
	} sag_ans_t;

	typedef struct packed {
		logic        valid;
		sag_seg_t    segId;
		logic [15:0] value;
	} sag_seg_load_t;

endpackage

// ==== sag_seg_bank.sv ====
// Purpose: four segment selector registers with one load port and one read port
// Assumes: load and read on the same clock; read is combinational
// Notes:   a read in the cycle of a load returns the old value
`timescale 1ns/100ps
`default_nettype none
module sag_seg_bank
	import sag_pkg::*;
(
	// clock and reset
	input  wire logic          core_clk,
	input  wire logic          reset_n,
	// load from the execution side
	input  wire sag_seg_load_t segLoad,
	// read
	input  wire sag_seg_t      readId,
	output logic [15:0]        readValue
);
	logic [15:0] seg_ff [4];

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 4; i++) begin
				seg_ff[i] <= SEG_RESET_VALUE;
			end
		end else if (segLoad.valid) begin
			seg_ff[segLoad.segId] <= segLoad.value;
		end
	end

	assign readValue = seg_ff[readId];
endmodule
`default_nettype wire

// ==== sag_offset_sum.sv ====
// Purpose: three-term offset adder for memory operands
// Assumes: terms not in use are gated to zero here
// Notes:   the sum wraps inside 16 bits; a carry out is dropped on purpose
`timescale 1ns/100ps
`default_nettype none
module sag_offset_sum
	import sag_pkg::*;
(
	// displacement term
	input  wire logic        useDisp,
	input  wire logic        dispWide,
	input  wire logic [15:0] disp,
	// register terms
	input  wire logic        useBase,
	input  wire logic [15:0] baseValue,
	input  wire logic        useIndex,
	input  wire logic [15:0] indexValue,
	// result
	output logic [15:0]      offset
);
	logic [15:0] dispExt;
	logic [15:0] dispTerm;
	logic [15:0] baseTerm;
	logic [15:0] indexTerm;

	// narrow displacement is signed, so small negative steps reach below the base
	assign dispExt   = dispWide ? disp : {{BYTE_W{disp[BYTE_SIGN_BIT]}}, disp[7:0]};
	assign dispTerm  = useDisp  ? dispExt    : WORD_ZERO;
	assign baseTerm  = useBase  ? baseValue  : WORD_ZERO;
	assign indexTerm = useIndex ? indexValue : WORD_ZERO;
	// 16-bit target keeps the sum modulo 2^16
	assign offset    = 16'(dispTerm + baseTerm + indexTerm);
endmodule
`default_nettype wire

// ==== sag_far_model.sv ====
// Purpose: far side of the address generator: register file owner and segment loader
// Assumes: general registers are fixed for the run; loads are one-cycle pulses
// Notes:   after a pulse the load fields are inverted so a late sample cannot pass
`timescale 1ns/100ps
`default_nettype none
module sag_far_model
	import sag_pkg::*;
#(
	parameter sag_gpr_t GPR_INIT = '0
)
(
	// clock
	input  wire logic          core_clk,
	// register state to the block
	output sag_gpr_t           gprFile,
	output var sag_seg_load_t  segLoad
);
	assign gprFile = GPR_INIT;

	initial segLoad = '0;

	task automatic loadSeg(input sag_seg_t id, input logic [15:0] v);
		@(posedge core_clk) segLoad <= '{valid: 1'b1, segId: id, value: v};
		@(posedge core_clk) segLoad <= '{valid: 1'b0, segId: sag_seg_t'(~id), value: ~v};
	endtask
endmodule
`default_nettype wire

// ==== segmented_address_generator_test.sv ====
// Purpose: self-checking bench for the address generator
// Assumes: one-cycle registered answer; segment ids EXTRA=0 CODE=1 STACK=2 DATA=3
// Notes:   expected offsets are worked by hand from the register image below
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module segmented_address_generator_test;
	import sag_pkg::*;
	// index 7 down to 0
	localparam sag_gpr_t GPR = {16'h9000, 16'h0102, 16'hFFF0, 16'h0404,
		16'h8001, 16'h0303, 16'h0202, 16'hAB01};
	logic          core_clk;
	logic          reset_n;
	sag_req_t      reqIn;
	sag_gpr_t      gprFile;
	sag_seg_load_t segLoad;
	sag_ans_t      ansOut;
	logic [15:0]   segv [4];
	int            num_errors;
	int            checks_done;

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	sag_far_model #(.GPR_INIT(GPR)) far (.core_clk(core_clk), .gprFile(gprFile), .segLoad(segLoad));
	sag_addr_gen DUT (.core_clk(core_clk), .reset_n(reset_n), .reqIn(reqIn), .gprFile(gprFile),
		.segLoad(segLoad), .ansOut(ansOut));

	function automatic sag_req_t mk(sag_ref_t k, sag_mode_t m, logic [2:0] ov, logic [3:0] sel,
		logic dw, logic [15:0] d);
		mk = '0;
		mk.valid = 1'b1;
		mk.refKind = k;
		mk.mode = m;
		mk.overrideValid = ov[2];
		mk.overrideSeg = sag_seg_t'(ov[1:0]);
		{mk.baseIsPointer, mk.indexIsDest, mk.indirSel} = sel;
		mk.dispWide = dw;
		mk.disp = d;
	endfunction

	task automatic issue(input sag_req_t r);
		@(posedge core_clk) reqIn <= r;
		@(posedge core_clk) reqIn.valid <= 1'b0;
		#1;
		`CHK(ansOut.valid, 1'b1)
	endtask

	task automatic run(input sag_req_t r, input sag_seg_t es, input logic [15:0] eo);
		issue(r);
		`CHK(ansOut.memAccess, 1'b1)
		`CHK(ansOut.segId, es)
		`CHK(ansOut.segValue, segv[es])
		`CHK(ansOut.offset, eo)
	endtask

	task automatic opnd(input sag_req_t r, input logic [15:0] ev);
		issue(r);
		`CHK(ansOut.memAccess, 1'b0)
		`CHK(ansOut.operandValid, 1'b1)
		`CHK(ansOut.operand, ev)
	endtask

	task automatic test_load_segs;
		run(mk(REF_OPERAND, MODE_DIRECT, 3'h0, 4'h0, 1'b1, 16'h0042), SEG_DATA, 16'h0042);
		for (int i = 0; i < 4; i++) begin
			segv[i] = 16'h1A00 + 16'(i) * 16'h2100;
			far.loadSeg(sag_seg_t'(i), segv[i]);
		end
		for (int i = 0; i < 4; i++) begin
			run(mk(REF_OPERAND, MODE_BASED_IDX_DISP, {1'b1, 2'(i)}, 4'h0, 1'b1, 16'h0), sag_seg_t'(i),
				16'h8103);
		end
	endtask

	task automatic test_implicit;
		run(mk(REF_PREFETCH, MODE_DIRECT, 3'h7, 4'h0, 1'b1, 16'hFFFE), SEG_CODE, 16'hFFFE);
		run(mk(REF_STACK, MODE_DIRECT, 3'h7, 4'h0, 1'b1, 16'h0100), SEG_STACK, 16'h0100);
		run(mk(REF_STRDST, MODE_DIRECT, 3'h7, 4'h0, 1'b1, 16'h0), SEG_EXTRA, 16'h9000);
		run(mk(REF_OPERAND, MODE_BASED, 3'h5, 4'h8, 1'b0, 16'h0), SEG_CODE, 16'hFFF0);
	endtask

	task automatic test_modes;
		run(mk(REF_OPERAND, MODE_DIRECT, 3'h0, 4'h0, 1'b0, 16'h3480), SEG_DATA, 16'hFF80);
		run(mk(REF_OPERAND, MODE_DIRECT, 3'h0, 4'h0, 1'b1, 16'h3480), SEG_DATA, 16'h3480);
		run(mk(REF_OPERAND, MODE_REG_INDIRECT, 3'h0, 4'h0, 1'b1, 16'h1), SEG_DATA, 16'h0102);
		run(mk(REF_OPERAND, MODE_REG_INDIRECT, 3'h0, 4'h1, 1'b1, 16'h1), SEG_DATA, 16'h9000);
		run(mk(REF_OPERAND, MODE_REG_INDIRECT, 3'h0, 4'h2, 1'b1, 16'h1), SEG_DATA, 16'h8001);
		run(mk(REF_OPERAND, MODE_REG_INDIRECT, 3'h0, 4'h3, 1'b1, 16'h1), SEG_STACK, 16'hFFF0);
		run(mk(REF_OPERAND, MODE_BASED, 3'h0, 4'h8, 1'b0, 16'h00FF), SEG_STACK, 16'hFFEF);
		run(mk(REF_OPERAND, MODE_BASED, 3'h0, 4'h0, 1'b1, 16'h8000), SEG_DATA, 16'h0001);
		run(mk(REF_OPERAND, MODE_INDEXED, 3'h0, 4'h0, 1'b0, 16'h0005), SEG_DATA, 16'h0107);
		run(mk(REF_OPERAND, MODE_INDEXED, 3'h0, 4'h4, 1'b1, 16'h7000), SEG_DATA, 16'h0000);
		run(mk(REF_OPERAND, MODE_BASED_INDEXED, 3'h0, 4'h0, 1'b1, 16'h1111), SEG_DATA, 16'h8103);
		run(mk(REF_OPERAND, MODE_BASED_INDEXED, 3'h0, 4'hC, 1'b1, 16'h1111), SEG_STACK, 16'h8FF0);
		run(mk(REF_OPERAND, MODE_BASED_IDX_DISP, 3'h0, 4'h8, 1'b0, 16'h0080), SEG_STACK, 16'h0072);
		run(mk(REF_OPERAND, MODE_BASED_IDX_DISP, 3'h0, 4'h4, 1'b1, 16'h1000), SEG_DATA, 16'h2001);
	endtask

	task automatic test_reg_imm;
		sag_req_t r;
		r = mk(REF_OPERAND, MODE_REGISTER, 3'h0, 4'h0, 1'b0, 16'h0);
		r.regSel = 3'h4;
		opnd(r, 16'h00AB);
		r.regSel = 3'h1;
		opnd(r, 16'h0002);
		r.regWide = 1'b1;
		r.regSel = 3'h5;
		opnd(r, 16'hFFF0);
		r.mode = MODE_IMMEDIATE;
		r.immValue = 16'h12F0;
		opnd(r, 16'h12F0);
		r.regWide = 1'b0;
		opnd(r, 16'h00F0);
	endtask

	// a load and a request in the same cycle: the request must still see the old selector
	task automatic test_back_to_back;
		fork
			far.loadSeg(SEG_DATA, 16'hBEEF);
			begin
				@(posedge core_clk) reqIn <= mk(REF_OPERAND, MODE_DIRECT, 3'h0, 4'h0, 1'b1, 16'h0010);
				@(posedge core_clk) reqIn <= mk(REF_OPERAND, MODE_DIRECT, 3'h0, 4'h0, 1'b1, 16'h0020);
				#1 `CHK(ansOut.segValue, segv[SEG_DATA])
				`CHK(ansOut.offset, 16'h0010)
				@(posedge core_clk) reqIn.valid <= 1'b0;
				#1 `CHK(ansOut.segValue, 16'hBEEF)
				`CHK(ansOut.offset, 16'h0020)
				@(posedge core_clk) #1 `CHK(ansOut.valid, 1'b0)
			end
		join
		segv[SEG_DATA] = 16'hBEEF;
	endtask

	task automatic stop_test;
		if (num_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// the whole sequence needs about 80 cycles
	initial begin
		repeat (3000) @(posedge core_clk);
		num_errors++;
		stop_test();
	end

	initial begin
		reset_n = 1'b0;
		reqIn = '0;
		segv = '{default: 16'h0000};
		num_errors = 0;
		checks_done = 0;
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		#1 `CHK(ansOut, sag_ans_t'(0))
		test_load_segs();
		test_implicit();
		test_modes();
		test_reg_imm();
		test_back_to_back();
		stop_test();
	end
endmodule
`default_nettype wire
